// ===== design/tcs_cfg.svh
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// Clock periods in ns: device link clock and host system clock.
`define TCS_LINK_NS 48
`define TCS_CLK_NS 20
// Timing figures in their own units.
`define TCS_T_RESET_US 10
`define TCS_T_INIT_MS 300
`define TCS_T_DATA_MS 1000
`define TCS_T_WR4_MS 40
`define TCS_T_WR8_MS 80
`define TCS_T_GAP_MS 10
`define TCS_T_HOLD_US 10
`define TCS_T_BUF_US 20
`define TCS_T_HALF_NS 1250
// Round a least time up to whole clock periods.
`define TCS_CEIL(t, p) (((t) + (p) - 1) / (p))
`define TCS_STRETCH 3'h3
// Bus addresses (7-bit form), status byte offset and its bit positions.
`define TCS_ID_ADDR 7'h50
`define TCS_DIAG_ADDR 7'h51
`define TCS_STATUS_OFS 8'h6E
`define TCS_SB_PIN 7
`define TCS_SB_SOFT 6
`define TCS_SB_FAULT 2
`define TCS_SB_LOS 1
`define TCS_SB_RDY 0
`define TCS_SHORT_WR 4'h4
`define TCS_MAX_WR 4'h8
`endif

// ===== design/tcs_pkg.sv
`default_nettype none
package tcs_pkg;
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_WDAT, D_ACK, D_RDAT, D_RACK} tcs_dev_state_t;
	typedef enum logic [3:0] {
		H_IDLE, H_STA_A, H_STA_B, H_LOW, H_HIGH, H_RS, H_STO_A, H_STO_B, H_BUF
	} tcs_host_state_t;
endpackage
`default_nettype wire

// ===== design/tcs_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tcs_link_if;
	logic tx_disable;
	logic tx_fault;
	logic rx_los;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic scl_d_o;
	logic scl_d_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;
	// Open-drain wires with pull-ups.
	assign scl = (scl_h_oe ? scl_h_o : 1'h1) & (scl_d_oe ? scl_d_o : 1'h1);
	assign sda = (sda_h_oe ? sda_h_o : 1'h1) & (sda_d_oe ? sda_d_o : 1'h1);
	modport dev (input tx_disable, scl, sda, output tx_fault, rx_los, scl_d_o, scl_d_oe, sda_d_o, sda_d_oe);
	modport host (input tx_fault, rx_los, scl, sda, output tx_disable, scl_h_o, scl_h_oe, sda_h_o, sda_h_oe);
endinterface
`default_nettype wire

// ===== design/tcs_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_dev #(
	parameter int INIT_CYC = `TCS_T_INIT_MS * 1000000 / `TCS_LINK_NS,
	parameter int DATA_CYC = `TCS_T_DATA_MS * 1000000 / `TCS_LINK_NS,
	parameter int WR4_CYC  = `TCS_T_WR4_MS * 1000000 / `TCS_LINK_NS,
	parameter int WR8_CYC  = `TCS_T_WR8_MS * 1000000 / `TCS_LINK_NS
) (
	// Module clock and power-on reset
	input  wire logic link_clk,
	input  wire logic sys_rst,
	// Host pins and management bus
	tcs_link_if.dev   lnk,
	// Optics side
	input  wire logic optical_present,
	input  wire logic laser_fault_det,
	output logic      laser_on
);
	localparam int CW      = 25;
	localparam int RST_CYC = `TCS_CEIL(`TCS_T_RESET_US * 1000, `TCS_LINK_NS);

	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] p_q;
	logic       dis;
	logic       scl_s;
	logic       sda_s;
	logic       opt_s;
	logic       flt_s;
	logic       dis_p;
	logic       scl_p;
	logic       sda_p;

	// Pins cross from the host domain through two flops.
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 5'h0C;
			s2_q <= 5'h0C;
			p_q  <= 5'h0C;
		end else begin
			s1_q <= {lnk.tx_disable, lnk.scl, lnk.sda, optical_present, laser_fault_det};
			s2_q <= s1_q;
			p_q  <= s2_q;
		end
	end
	assign {dis, scl_s, sda_s, opt_s, flt_s} = s2_q;
	assign {dis_p, scl_p, sda_p} = p_q[4:2];

	logic [CW-1:0] pwr_q, pwr_d;
	logic [7:0]    hold_q, hold_d;
	logic          fault_q, fault_d;
	logic          los_q, los_d;
	logic          laser_q, laser_d;
	logic          soft_q, soft_d;
	logic          ready;
	logic          dready;
	logic [7:0]    status;

	always_comb begin
		ready   = pwr_q >= CW'(INIT_CYC);
		dready  = pwr_q == CW'(DATA_CYC);
		pwr_d   = dready ? pwr_q : pwr_q + CW'(1);
		hold_d  = !dis ? 8'h00 : (hold_q == 8'(RST_CYC)) ? hold_q : hold_q + 8'h1;
		fault_d = fault_q | flt_s;
		if (!dis && dis_p && hold_q == 8'(RST_CYC)) begin
			fault_d = flt_s;
		end
		los_d   = ~opt_s;
		laser_d = ready & ~dis & ~soft_q & ~fault_d;
		status  = 8'h00;
		status[`TCS_SB_PIN]   = dis;
		status[`TCS_SB_SOFT]  = soft_q;
		status[`TCS_SB_FAULT] = fault_q;
		status[`TCS_SB_LOS]   = los_q;
		status[`TCS_SB_RDY]   = dready;
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_q   <= '0;
			hold_q  <= 8'h00;
			fault_q <= 1'h0;
			los_q   <= 1'h1;
			laser_q <= 1'h0;
		end else begin
			pwr_q   <= pwr_d;
			hold_q  <= hold_d;
			fault_q <= fault_d;
			los_q   <= los_d;
			laser_q <= laser_d;
		end
	end

	tcs_pkg::tcs_dev_state_t st_q, st_d, aft_q, aft_d;
	logic [2:0]    bit_q, bit_d;
	logic [7:0]    sh_q, sh_d;
	logic [7:0]    ptr_q, ptr_d;
	logic          page_q, page_d;
	logic [3:0]    nb_q, nb_d;
	logic [CW-1:0] wc_q, wc_d;
	logic [2:0]    str_q, str_d;
	logic          sda_oe_q, sda_oe_d;
	logic          scl_oe_q, scl_oe_d;
	logic          pend_q, pend_d;
	logic          pval_q, pval_d;
	logic [7:0]    mem [0:511];
	logic          mem_we;
	logic          start;
	logic          stop;
	logic          rise;
	logic          fall;
	logic          busy;
	logic          is_stat;
	logic [7:0]    rd_byte;

	always_comb begin
		start   = scl_s & scl_p & sda_p & ~sda_s;
		stop    = scl_s & scl_p & ~sda_p & sda_s;
		rise    = scl_s & ~scl_p;
		fall    = ~scl_s & scl_p;
		busy    = wc_q != '0;
		is_stat = page_q && ptr_q == `TCS_STATUS_OFS;
		rd_byte = is_stat ? status : mem[{page_q, ptr_q}];
		st_d    = st_q;
		aft_d   = aft_q;
		bit_d   = bit_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		page_d  = page_q;
		nb_d    = nb_q;
		pend_d  = pend_q;
		pval_d  = pval_q;
		soft_d  = soft_q;
		sda_oe_d = sda_oe_q;
		mem_we  = 1'h0;
		wc_d    = busy ? wc_q - CW'(1) : wc_q;
		str_d   = (str_q != 3'h0) ? str_q - 3'h1 : str_q;
		if (rise && (st_q == tcs_pkg::D_ADDR || st_q == tcs_pkg::D_PTR || st_q == tcs_pkg::D_WDAT)) begin
			sh_d = {sh_q[6:0], sda_s};
		end
		if (start) begin
			// The clock fall that closes a start carries no bit, so the acknowledge state absorbs it.
			st_d     = tcs_pkg::D_ACK;
			aft_d    = tcs_pkg::D_ADDR;
			bit_d    = 3'h0;
			sda_oe_d = 1'h0;
			nb_d     = 4'h0;
		end else if (stop) begin
			st_d     = tcs_pkg::D_IDLE;
			sda_oe_d = 1'h0;
			nb_d     = 4'h0;
			if (nb_q != 4'h0) begin
				wc_d = (nb_q <= `TCS_SHORT_WR) ? CW'(WR4_CYC) : CW'(WR8_CYC);
			end
			if (pend_q) begin
				soft_d = pval_q;
				pend_d = 1'h0;
			end
		end else if (fall) begin
			case (st_q)
				tcs_pkg::D_ADDR, tcs_pkg::D_PTR, tcs_pkg::D_WDAT: begin
					bit_d = bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						st_d     = tcs_pkg::D_ACK;
						sda_oe_d = 1'h1;
						if (st_q == tcs_pkg::D_ADDR) begin
							page_d = sh_q[1];
							aft_d  = sh_q[0] ? tcs_pkg::D_RDAT : tcs_pkg::D_PTR;
							if (!ready || busy || (sh_q[7:1] != `TCS_ID_ADDR && sh_q[7:1] != `TCS_DIAG_ADDR)) begin
								st_d     = tcs_pkg::D_IDLE;
								sda_oe_d = 1'h0;
							end
						end else if (st_q == tcs_pkg::D_PTR) begin
							ptr_d = sh_q;
							aft_d = tcs_pkg::D_WDAT;
						end else if (nb_q == `TCS_MAX_WR) begin
							st_d     = tcs_pkg::D_IDLE;
							sda_oe_d = 1'h0;
						end else begin
							mem_we = ~is_stat;
							if (is_stat) begin
								pend_d = 1'h1;
								pval_d = sh_q[`TCS_SB_SOFT];
							end
							ptr_d = ptr_q + 8'h1;
							nb_d  = nb_q + 4'h1;
						end
					end
				end
				tcs_pkg::D_ACK, tcs_pkg::D_RACK: begin
					sda_oe_d = 1'h0;
					st_d     = aft_q;
					bit_d    = 3'h0;
					if (aft_q == tcs_pkg::D_RDAT) begin
						sh_d     = rd_byte;
						ptr_d    = ptr_q + 8'h1;
						sda_oe_d = ~rd_byte[7];
						str_d    = `TCS_STRETCH;
					end
				end
				tcs_pkg::D_RDAT: begin
					bit_d    = bit_q + 3'h1;
					sh_d     = {sh_q[6:0], 1'h0};
					sda_oe_d = ~sh_q[6];
					if (bit_q == 3'h7) begin
						st_d     = tcs_pkg::D_RACK;
						sda_oe_d = 1'h0;
					end
				end
				default: begin
				end
			endcase
		end else if (rise && st_q == tcs_pkg::D_RACK && sda_s) begin
			st_d = tcs_pkg::D_IDLE;
		end
		scl_oe_d = str_d != 3'h0;
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q     <= tcs_pkg::D_IDLE;
			aft_q    <= tcs_pkg::D_IDLE;
			bit_q    <= 3'h0;
			sh_q     <= 8'h00;
			ptr_q    <= 8'h00;
			page_q   <= 1'h0;
			nb_q     <= 4'h0;
			wc_q     <= '0;
			str_q    <= 3'h0;
			sda_oe_q <= 1'h0;
			scl_oe_q <= 1'h0;
			pend_q   <= 1'h0;
			pval_q   <= 1'h0;
			soft_q   <= 1'h0;
		end else begin
			st_q     <= st_d;
			aft_q    <= aft_d;
			bit_q    <= bit_d;
			sh_q     <= sh_d;
			ptr_q    <= ptr_d;
			page_q   <= page_d;
			nb_q     <= nb_d;
			wc_q     <= wc_d;
			str_q    <= str_d;
			sda_oe_q <= sda_oe_d;
			scl_oe_q <= scl_oe_d;
			pend_q   <= pend_d;
			pval_q   <= pval_d;
			soft_q   <= soft_d;
		end
	end

	always_ff @(posedge link_clk) begin
		if (mem_we) begin
			mem[{page_q, ptr_q}] <= sh_q;
		end
	end

	assign lnk.tx_fault = fault_q;
	assign lnk.rx_los   = los_q;
	assign lnk.scl_d_o  = 1'h0;
	assign lnk.sda_d_o  = 1'h0;
	assign lnk.scl_d_oe = scl_oe_q;
	assign lnk.sda_d_oe = sda_oe_q;
	assign laser_on     = laser_q;
endmodule
`default_nettype wire

// ===== design/tcs_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_host #(
	parameter int GAP_CYC = `TCS_CEIL(`TCS_T_GAP_MS * 1000000, `TCS_CLK_NS)
) (
	// System clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Module pins and management bus
	tcs_link_if.host        lnk,
	// Laser disable request
	input  wire logic       dis_req,
	// Single byte register access
	input  wire logic       req,
	input  wire logic       wr,
	input  wire logic       page,
	input  wire logic [7:0] offset,
	input  wire logic [7:0] wdata,
	output logic            busy,
	output logic            done,
	output logic            nack,
	output logic [7:0]      rdata,
	// Module status pins
	output logic            fault_seen,
	output logic            los_seen
);
	localparam int HOLD_CYC = `TCS_CEIL(`TCS_T_HOLD_US * 1000, `TCS_CLK_NS);
	localparam int BUF_CYC  = `TCS_CEIL(`TCS_T_BUF_US * 1000, `TCS_CLK_NS);
	localparam int HALF_CYC = `TCS_CEIL(`TCS_T_HALF_NS, `TCS_CLK_NS);

	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic       scl_s;
	logic       sda_s;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 4'hC;
			s2_q <= 4'hC;
		end else begin
			s1_q <= {lnk.scl, lnk.sda, lnk.tx_fault, lnk.rx_los};
			s2_q <= s1_q;
		end
	end
	assign {scl_s, sda_s, fault_seen, los_seen} = s2_q;

	logic        dis_q, dis_d;
	logic [18:0] gap_q, gap_d;
	logic [8:0]  hold_q, hold_d;

	always_comb begin
		dis_d  = dis_q;
		gap_d  = (gap_q != 19'h0) ? gap_q - 19'h1 : gap_q;
		hold_d = (hold_q != 9'h0) ? hold_q - 9'h1 : hold_q;
		if (!dis_q && dis_req && gap_q == 19'h0) begin
			dis_d  = 1'h1;
			gap_d  = 19'(GAP_CYC);
			hold_d = 9'(HOLD_CYC);
		end else if (dis_q && !dis_req && hold_q == 9'h0) begin
			dis_d = 1'h0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dis_q  <= 1'h0;
			gap_q  <= 19'h0;
			hold_q <= 9'h0;
		end else begin
			dis_q  <= dis_d;
			gap_q  <= gap_d;
			hold_q <= hold_d;
		end
	end

	tcs_pkg::tcs_host_state_t st_q, st_d;
	logic [9:0] tm_q, tm_d;
	logic [1:0] step_q, step_d;
	logic [3:0] bit_q, bit_d;
	logic [8:0] tx_q, tx_d;
	logic [8:0] rx_q, rx_d;
	logic       scl_oe_q, scl_oe_d;
	logic       sda_oe_q, sda_oe_d;
	logic       busy_q, busy_d;
	logic       done_q, done_d;
	logic       nack_q, nack_d;
	logic [7:0] rd_q, rd_d;
	logic       wr_q, wr_d;
	logic       pg_q, pg_d;
	logic [7:0] ofs_q, ofs_d;
	logic [7:0] wd_q, wd_d;
	logic       last;
	logic       tm_zero;

	function automatic logic [7:0] step_byte(input logic [1:0] s, input logic w, input logic p,
		input logic [7:0] o, input logic [7:0] d);
		logic [7:0] b;
		b = 8'hFF;
		case (s)
			2'h0: b = {(p ? `TCS_DIAG_ADDR : `TCS_ID_ADDR), 1'h0};
			2'h1: b = o;
			2'h2: b = w ? d : {(p ? `TCS_DIAG_ADDR : `TCS_ID_ADDR), 1'h1};
			default: b = 8'hFF;
		endcase
		return b;
	endfunction

	always_comb begin
		st_d   = st_q;
		step_d = step_q;
		bit_d  = bit_q;
		tx_d   = tx_q;
		rx_d   = rx_q;
		busy_d = busy_q;
		done_d = 1'h0;
		nack_d = nack_q;
		rd_d   = rd_q;
		wr_d   = wr_q;
		pg_d   = pg_q;
		ofs_d  = ofs_q;
		wd_d   = wd_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		last    = wr_q ? step_q == 2'h2 : step_q == 2'h3;
		tm_zero = tm_q == 10'h0;
		// The high phase waits for a stretched clock to be released.
		tm_d = (tm_zero || ((st_q == tcs_pkg::H_STA_A || st_q == tcs_pkg::H_STO_B || st_q == tcs_pkg::H_HIGH) && !scl_s))
			? tm_q : tm_q - 10'h1;
		case (st_q)
			tcs_pkg::H_IDLE: begin
				scl_oe_d = 1'h0;
				sda_oe_d = 1'h0;
				if (req) begin
					wr_d   = wr;
					pg_d   = page;
					ofs_d  = offset;
					wd_d   = wdata;
					busy_d = 1'h1;
					nack_d = 1'h0;
					step_d = 2'h0;
					tm_d   = 10'(HALF_CYC);
					st_d   = tcs_pkg::H_STA_A;
				end
			end
			tcs_pkg::H_STA_A: if (tm_zero) begin
				sda_oe_d = 1'h1;
				tm_d     = 10'(HALF_CYC);
				st_d     = tcs_pkg::H_STA_B;
			end
			tcs_pkg::H_STA_B: if (tm_zero) begin
				scl_oe_d = 1'h1;
				tx_d     = {step_byte(step_q, wr_q, pg_q, ofs_q, wd_q), 1'h1};
				bit_d    = 4'h0;
				tm_d     = 10'(HALF_CYC);
				st_d     = tcs_pkg::H_LOW;
			end
			tcs_pkg::H_LOW: begin
				sda_oe_d = ~tx_q[8];
				if (tm_zero) begin
					scl_oe_d = 1'h0;
					tm_d     = 10'(HALF_CYC);
					st_d     = tcs_pkg::H_HIGH;
				end
			end
			tcs_pkg::H_HIGH: if (tm_zero) begin
				rx_d     = {rx_q[7:0], sda_s};
				tx_d     = {tx_q[7:0], 1'h1};
				scl_oe_d = 1'h1;
				tm_d     = 10'(HALF_CYC);
				bit_d    = bit_q + 4'h1;
				st_d     = tcs_pkg::H_LOW;
				if (bit_q == 4'h8) begin
					bit_d = 4'h0;
					if (step_q != 2'h3 && sda_s) begin
						nack_d = 1'h1;
						st_d   = tcs_pkg::H_STO_A;
					end else if (last) begin
						rd_d = rx_d[8:1];
						st_d = tcs_pkg::H_STO_A;
					end else begin
						step_d = step_q + 2'h1;
						tx_d   = {step_byte(step_q + 2'h1, wr_q, pg_q, ofs_q, wd_q), 1'h1};
						if (!wr_q && step_q == 2'h1) begin
							st_d = tcs_pkg::H_RS;
						end
					end
				end
			end
			tcs_pkg::H_RS: begin
				sda_oe_d = 1'h0;
				if (tm_zero) begin
					scl_oe_d = 1'h0;
					tm_d     = 10'(HALF_CYC);
					st_d     = tcs_pkg::H_STA_A;
				end
			end
			tcs_pkg::H_STO_A: begin
				sda_oe_d = 1'h1;
				if (tm_zero) begin
					scl_oe_d = 1'h0;
					tm_d     = 10'(HALF_CYC);
					st_d     = tcs_pkg::H_STO_B;
				end
			end
			tcs_pkg::H_STO_B: if (tm_zero) begin
				sda_oe_d = 1'h0;
				tm_d     = 10'(BUF_CYC);
				st_d     = tcs_pkg::H_BUF;
			end
			tcs_pkg::H_BUF: if (tm_zero) begin
				busy_d = 1'h0;
				done_d = 1'h1;
				st_d   = tcs_pkg::H_IDLE;
			end
			default: st_d = tcs_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q     <= tcs_pkg::H_IDLE;
			tm_q     <= 10'h0;
			step_q   <= 2'h0;
			bit_q    <= 4'h0;
			tx_q     <= 9'h1FF;
			rx_q     <= 9'h000;
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
			busy_q   <= 1'h0;
			done_q   <= 1'h0;
			nack_q   <= 1'h0;
			rd_q     <= 8'h00;
			wr_q     <= 1'h0;
			pg_q     <= 1'h0;
			ofs_q    <= 8'h00;
			wd_q     <= 8'h00;
		end else begin
			st_q     <= st_d;
			tm_q     <= tm_d;
			step_q   <= step_d;
			bit_q    <= bit_d;
			tx_q     <= tx_d;
			rx_q     <= rx_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			busy_q   <= busy_d;
			done_q   <= done_d;
			nack_q   <= nack_d;
			rd_q     <= rd_d;
			wr_q     <= wr_d;
			pg_q     <= pg_d;
			ofs_q    <= ofs_d;
			wd_q     <= wd_d;
		end
	end

	assign lnk.tx_disable = dis_q;
	assign lnk.scl_h_o    = 1'h0;
	assign lnk.sda_h_o    = 1'h0;
	assign lnk.scl_h_oe   = scl_oe_q;
	assign lnk.sda_h_oe   = sda_oe_q;
	assign busy           = busy_q;
	assign done           = done_q;
	assign nack           = nack_q;
	assign rdata          = rd_q;
endmodule
`default_nettype wire

// ===== tb/tcs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_checker #(
	parameter int INIT_CYC = 2000,
	parameter int GAP_CYC  = 2000
) (
	// Clocks and reset
	input wire logic clock,
	input wire logic link_clk,
	input wire logic sys_rst,
	// Disable and fault pins
	input wire logic tx_disable,
	input wire logic tx_fault,
	// Bus drivers and resolved wires
	input wire logic scl_h_o,
	input wire logic sda_h_o,
	input wire logic scl_d_o,
	input wire logic sda_d_o,
	input wire logic scl_d_oe,
	input wire logic sda_d_oe,
	input wire logic scl,
	input wire logic sda
);
	localparam int PER_MIN  = 124;
	localparam int BUF_MIN  = 999;
	localparam int HOLD_MIN = 498;
	localparam int LINK_MIN = 208;
	localparam int GAP_MIN  = GAP_CYC - 2;
	localparam int INIT_MIN = INIT_CYC - 4;
	logic        scl_q, scl_d, sda_q, sda_d, dis_q, dis_d, ldis_q, ldis_d;
	logic [15:0] per_q, per_d, buf_q, buf_d, gap_q, gap_d, hold_q, hold_d;
	logic [15:0] init_q, init_d, lhi_q, lhi_d;

	function automatic logic [15:0] sat(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h1;
	endfunction

	// Host clocks since the last SCL rise, stop, and disable rise; length of the disable pulse.
	always_comb begin
		scl_d  = scl;
		sda_d  = sda;
		dis_d  = tx_disable;
		per_d  = (scl && !scl_q) ? 16'h0 : sat(per_q);
		buf_d  = (scl && scl_q && sda && !sda_q) ? 16'h0 : sat(buf_q);
		gap_d  = (tx_disable && !dis_q) ? 16'h0 : sat(gap_q);
		hold_d = (tx_disable && !dis_q) ? 16'h0 : (tx_disable ? sat(hold_q) : hold_q);
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q  <= 1'h1;
			sda_q  <= 1'h1;
			dis_q  <= 1'h0;
			per_q  <= 16'hFFFF;
			buf_q  <= 16'hFFFF;
			gap_q  <= 16'hFFFF;
			hold_q <= 16'h0;
		end else begin
			scl_q  <= scl_d;
			sda_q  <= sda_d;
			dis_q  <= dis_d;
			per_q  <= per_d;
			buf_q  <= buf_d;
			gap_q  <= gap_d;
			hold_q <= hold_d;
		end
	end

	// Link clocks since reset, and length of the latest disable pulse in link clocks.
	always_comb begin
		ldis_d = tx_disable;
		init_d = sat(init_q);
		lhi_d  = (tx_disable && !ldis_q) ? 16'h1 : (tx_disable ? sat(lhi_q) : lhi_q);
	end
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ldis_q <= 1'h0;
			init_q <= 16'h0;
			lhi_q  <= 16'h0;
		end else begin
			ldis_q <= ldis_d;
			init_q <= init_d;
			lhi_q  <= lhi_d;
		end
	end

	drive_low_a: assert property (@(posedge clock) disable iff (sys_rst)
		!scl_h_o && !sda_h_o && !scl_d_o && !sda_d_o) else $error("open drain output driven high");
	scl_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
		(scl && !scl_q) |-> per_q >= PER_MIN) else $error("bus clock period too short");
	bus_free_a: assert property (@(posedge clock) disable iff (sys_rst)
		(scl && scl_q && !sda && sda_q) |-> buf_q >= BUF_MIN) else $error("start too soon after stop");
	dis_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(tx_disable) |-> gap_q >= GAP_MIN) else $error("disable asserted too soon");
	dis_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(tx_disable) |-> hold_q >= HOLD_MIN) else $error("disable pulse too short");
	fault_clear_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		$fell(tx_fault) |-> !tx_disable && lhi_q >= LINK_MIN) else $error("fault cleared without long pulse");
	init_quiet_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		(init_q < INIT_MIN) |-> !sda_d_oe && !scl_d_oe) else $error("bus answered before ready");
	stretch_len_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		$rose(scl_d_oe) |-> scl_d_oe[*3] ##1 !scl_d_oe) else $error("clock stretch length wrong");
	sda_edge_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		$changed(sda_d_oe) |-> !scl) else $error("data changed while clock high");
endmodule
`default_nettype wire

// ===== tb/transceiver_control_status_timing_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module transceiver_control_status_timing_bench;
	localparam int INIT = 2000;
	localparam int DATA = 8000;
	localparam int WR4  = 2000;
	localparam int GAP  = 2000;
	logic       clock = 1'h0;
	logic       link_clk = 1'h0;
	logic       sys_rst = 1'h1;
	logic       optical_present = 1'h1;
	logic       laser_fault_det = 1'h0;
	logic       dis_req = 1'h0;
	logic       req = 1'h0;
	logic       wr = 1'h0;
	logic       page = 1'h0;
	logic [7:0] offset = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       busy, done, nack, fault_seen, los_seen, laser_on;
	logic [7:0] rdata;
	int         n_mismatch = 0;
	int         n_tests = 0;
	int         cyc = 0;
	tcs_link_if lnk ();

	always #10 clock = ~clock;
	initial begin
		#3;
		forever #24 link_clk = ~link_clk;
	end

	tcs_dev #(.INIT_CYC(INIT), .DATA_CYC(DATA), .WR4_CYC(WR4), .WR8_CYC(2 * WR4)) tcs_dev_inst (
		.link_clk(link_clk), .sys_rst(sys_rst), .lnk(lnk), .optical_present(optical_present),
		.laser_fault_det(laser_fault_det), .laser_on(laser_on));
	tcs_host #(.GAP_CYC(GAP)) tcs_host_inst (
		.clock(clock), .sys_rst(sys_rst), .lnk(lnk), .dis_req(dis_req), .req(req), .wr(wr), .page(page),
		.offset(offset), .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata),
		.fault_seen(fault_seen), .los_seen(los_seen));
	tcs_checker #(.INIT_CYC(INIT), .GAP_CYC(GAP)) tcs_checker_inst (
		.clock(clock), .link_clk(link_clk), .sys_rst(sys_rst), .tx_disable(lnk.tx_disable),
		.tx_fault(lnk.tx_fault), .scl_h_o(lnk.scl_h_o), .sda_h_o(lnk.sda_h_o), .scl_d_o(lnk.scl_d_o),
		.sda_d_o(lnk.sda_d_o), .scl_d_oe(lnk.scl_d_oe), .sda_d_oe(lnk.sda_d_oe), .scl(lnk.scl), .sda(lnk.sda));

	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wait_cyc(input int c);
		while (cyc < c)
			@(negedge clock);
	endtask

	// One register access; returns once the done pulse is seen, unless the run timeout ends the simulation first.
	task automatic acc(input logic w, input logic p, input logic [7:0] o, input logic [7:0] d);
		@(negedge clock);
		req = 1'h1;
		wr = w;
		page = p;
		offset = o;
		wdata = d;
		@(negedge clock);
		req = 1'h0;
		chk1(busy, 1'h1);
		while (done !== 1'h1)
			@(negedge clock);
	endtask
	task automatic rd_stat(input logic [7:0] exp);
		acc(1'h0, 1'h1, `TCS_STATUS_OFS, 8'h00);
		chk1(nack, 1'h0);
		chk8(rdata, exp);
	endtask

	task automatic t_early();
		chk1(lnk.scl & lnk.sda, 1'h1);
		acc(1'h0, 1'h1, `TCS_STATUS_OFS, 8'h00);
		chk1(nack, 1'h1);
	endtask
	task automatic t_ready();
		wait_cyc(INIT * 48 / 20 + 100);
		rd_stat(8'h00);
		acc(1'h0, 1'h0, 8'h00, 8'h00);
		chk1(nack, 1'h0);
	endtask
	task automatic t_soft();
		wait_cyc(DATA * 48 / 20 + 100);
		chk1(laser_on, 1'h1);
		acc(1'h1, 1'h1, `TCS_STATUS_OFS, 8'h40);
		chk1(nack, 1'h0);
		chk1(laser_on, 1'h0);
		acc(1'h0, 1'h1, `TCS_STATUS_OFS, 8'h00);
		chk1(nack, 1'h1);
		ticks(2000);
		rd_stat(8'h41);
		acc(1'h1, 1'h1, `TCS_STATUS_OFS, 8'h00);
		chk1(laser_on, 1'h1);
		ticks(WR4 * 48 / 20 + 100);
	endtask
	task automatic t_pin();
		dis_req = 1'h1;
		ticks(20);
		chk1(lnk.tx_disable, 1'h1);
		chk1(laser_on, 1'h0);
		rd_stat(8'h81);
		dis_req = 1'h0;
		ticks(40);
		chk1(laser_on, 1'h1);
	endtask
	task automatic t_fault();
		laser_fault_det = 1'h1;
		ticks(20);
		chk1(fault_seen, 1'h1);
		chk1(lnk.tx_fault, 1'h1);
		chk1(laser_on, 1'h0);
		rd_stat(8'h05);
		laser_fault_det = 1'h0;
		dis_req = 1'h1;
		ticks(600);
		dis_req = 1'h0;
		ticks(2);
		dis_req = 1'h1;
		ticks(40);
		chk1(lnk.tx_disable, 1'h0);
		chk1(fault_seen, 1'h0);
		chk1(laser_on, 1'h1);
		ticks(GAP);
		chk1(lnk.tx_disable, 1'h1);
		dis_req = 1'h0;
		ticks(600);
	endtask
	task automatic t_los();
		optical_present = 1'h0;
		ticks(20);
		chk1(los_seen, 1'h1);
		chk1(lnk.rx_los, 1'h1);
		rd_stat(8'h03);
		optical_present = 1'h1;
		ticks(20);
		chk1(los_seen, 1'h0);
		rd_stat(8'h01);
	endtask

	initial begin
		ticks(10);
		sys_rst = 1'h0;
		t_early();
		t_ready();
		t_soft();
		t_pin();
		t_fault();
		t_los();
		stop_test();
	end
endmodule
`default_nettype wire
